//--- rtl/sag_address_gen.sv
`timescale 1ns/1ps
`default_nettype none

`include "sag_defines.svh"

module sag_address_gen
  import sag_pkg::*;
#(
  parameter int WORD_W = `SAG_WORD_W
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Segment register loads
  input  wire sag_segwr_t  segWr,
  // Offset register file values
  input  wire logic [15:0] generalBaseReg,
  input  wire logic [15:0] basePointerReg,
  input  wire logic [15:0] srcIndexReg,
  input  wire logic [15:0] destIndexReg,
  // Decoder request
  input  wire sag_req_t    req,
  // Address toward memory management
  output sag_addr_t        addrOut,
  // Segment register readback
  output logic [15:0]      codeSegmentReg,
  output logic [15:0]      stackSegmentReg,
  output logic [15:0]      dataSegmentReg,
  output logic [15:0]      extraSegmentReg
);

  // Only a 16-bit datapath is built; wider words break the pointer format
  if (WORD_W != 16) begin : gWidthCheck
    $error("sag_address_gen supports WORD_W of 16 only");
  end

  // Segment decode below assumes exactly four registers
  if (`SAG_SEG_CNT != 4) begin : gSegCntCheck
    $error("sag_address_gen needs exactly four segment registers");
  end

  // The segment code must reach every register of the file
  if ((1 << $bits(sag_seg_t)) < `SAG_SEG_CNT) begin : gSegCodeCheck
    $error("sag_address_gen segment code too narrow for the file");
  end

  // A short displacement must be narrower than the word it widens into
  if (`SAG_DISP8_W < 1 || `SAG_DISP8_W >= 16) begin : gDispCheck
    $error("sag_address_gen needs a short displacement narrower than a word");
  end

  // One segment spans exactly what an offset can reach
  if (`SAG_SEG_BYTES != (32'h0000_0001 << WORD_W)) begin : gSegSizeCheck
    $error("sag_address_gen segment size must match the offset range");
  end

  // A single register stage sits between request and address
  if (`SAG_LATENCY != 1) begin : gLatencyCheck
    $error("sag_address_gen has a fixed one-cycle latency");
  end

  // Segment register state
  logic [15:0] segFile_r   [`SAG_SEG_CNT];
  logic [15:0] segFile_nxt [`SAG_SEG_CNT];

  // Output state
  sag_addr_t addr_r;
  sag_addr_t addr_nxt;

  // Offset elements after width and register choice
  logic [15:0] dispExt;
  logic [15:0] baseVal;
  logic [15:0] indexVal;
  logic [15:0] indirVal;

  // Adder terms; a term that a mode does not use is held at zero
  logic [15:0] termDisp;
  logic [15:0] termBase;
  logic [15:0] termIndex;
  logic [15:0] offsetSum;
  logic        makesAddr;

  // Segment choice
  sag_seg_t    implicitSeg;
  sag_seg_t    chosenSeg;
  logic        ovrApplies;

  // Pick one offset register by code
  function automatic logic [15:0] pickReg(input sag_reg_t sel,
                                          input logic [15:0] si,
                                          input logic [15:0] di,
                                          input logic [15:0] gb,
                                          input logic [15:0] bp);
    logic [15:0] val;
    val = 16'h0000;
    case (sel)
      SAG_R_SRCIDX: val = si;
      SAG_R_DSTIDX: val = di;
      SAG_R_GBASE:  val = gb;
      SAG_R_BPTR:   val = bp;
      default:      val = 16'h0000;
    endcase
    return val;
  endfunction

  // Widen a short displacement by copying its sign bit upward
  function automatic logic [15:0] signExtDisp(input logic [15:0] raw);
    logic [15:0] val;
    val = {{(16 - `SAG_DISP8_W){raw[`SAG_DISP8_W-1]}}, raw[`SAG_DISP8_W-1:0]};
    return val;
  endfunction

  // True when the offset takes the base pointer as its base element;
  // such data references default to the stack segment
  function automatic logic usesBasePtr(input sag_mode_t mode,
                                       input logic      baseIsPtr,
                                       input sag_reg_t  indirReg);
    logic hit;
    hit = 1'b0;
    case (mode)
      SAG_AM_BASED:    hit = baseIsPtr;
      SAG_AM_BIX:      hit = baseIsPtr;
      SAG_AM_BIX_DISP: hit = baseIsPtr;
      SAG_AM_INDIRECT: hit = (indirReg == SAG_R_BPTR);
      default:         hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Segment register next values; loads apply on the next edge
  // A request in the load cycle still reads the old value
  always_comb begin
    for (int i = 0; i < `SAG_SEG_CNT; i++) begin
      segFile_nxt[i] = segFile_r[i];
    end
    if (segWr.we) begin
      segFile_nxt[segWr.seg] = segWr.value;
    end
  end

  // Four 16-bit segment registers, cleared at reset
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < `SAG_SEG_CNT; i++) begin
      if (rst) begin
        segFile_r[i] <= `SAG_SEG_RST;
      end else begin
        segFile_r[i] <= segFile_nxt[i];
      end
    end
  end

  // Readback of the segment registers
  // Taken straight from the flops; a load shows one cycle later
  always_comb begin
    codeSegmentReg  = segFile_r[SAG_SEG_CODE];
    stackSegmentReg = segFile_r[SAG_SEG_STACK];
    dataSegmentReg  = segFile_r[SAG_SEG_DATA];
    extraSegmentReg = segFile_r[SAG_SEG_EXTRA];
  end

  // Displacement width and element values
  always_comb begin
    if (req.disp16) begin
      dispExt = req.disp;
    end else begin
      dispExt = signExtDisp(req.disp);
    end
    baseVal  = req.baseIsPtr ? basePointerReg : generalBaseReg;
    indexVal = req.indexIsDst ? destIndexReg : srcIndexReg;
    indirVal = pickReg(req.indirReg, srcIndexReg, destIndexReg,
                       generalBaseReg, basePointerReg);
  end

  // Mode selects which terms enter the adder; unused terms are zero
  // Unknown mode codes make no address rather than a stray one
  always_comb begin
    termDisp  = 16'h0000;
    termBase  = 16'h0000;
    termIndex = 16'h0000;
    makesAddr = 1'b1;
    case (req.mode)
      SAG_AM_REG: begin
        makesAddr = 1'b0;
      end
      SAG_AM_IMM: begin
        makesAddr = 1'b0;
      end
      SAG_AM_DIRECT: begin
        termDisp = dispExt;
      end
      SAG_AM_INDIRECT: begin
        termBase = indirVal;
      end
      SAG_AM_BASED: begin
        termDisp = dispExt;
        termBase = baseVal;
      end
      SAG_AM_INDEXED: begin
        termDisp  = dispExt;
        termIndex = indexVal;
      end
      SAG_AM_BIX: begin
        termBase  = baseVal;
        termIndex = indexVal;
      end
      SAG_AM_BIX_DISP: begin
        termDisp  = dispExt;
        termBase  = baseVal;
        termIndex = indexVal;
      end
      default: begin
        makesAddr = 1'b0;
      end
    endcase
    // Fetches ignore mode and use the instruction pointer
    // Prefetch shares this path, so its mode bits are don't-care
    if (req.refKind == SAG_REF_FETCH) begin
      termDisp  = req.fetchPtr;
      termBase  = 16'h0000;
      termIndex = 16'h0000;
      makesAddr = 1'b1;
    end
  end

  // Shared wrapping adder; the offset never leaves its 64K segment
  // One adder for all modes keeps carry handling in a single place
  sag_offset_adder #(
    .WORD_W (16)
  ) uAdder (
    .termDisp  (termDisp),
    .termBase  (termBase),
    .termIndex (termIndex),
    .sum       (offsetSum)
  );

  // Implicit segment choice; base pointer use forces stack on data refs
  always_comb begin
    implicitSeg = SAG_SEG_DATA;
    case (req.refKind)
      SAG_REF_FETCH: implicitSeg = SAG_SEG_CODE;
      SAG_REF_STACK: implicitSeg = SAG_SEG_STACK;
      SAG_REF_SDST:  implicitSeg = SAG_SEG_EXTRA;
      SAG_REF_DATA: begin
        if (usesBasePtr(req.mode, req.baseIsPtr, req.indirReg)) begin
          implicitSeg = SAG_SEG_STACK;
        end else begin
          implicitSeg = SAG_SEG_DATA;
        end
      end
      default: implicitSeg = SAG_SEG_DATA;
    endcase
    // Override applies to data operands only; fetch, stack and string
    // destination stay fixed, so a stray prefix cannot misroute them
    ovrApplies = req.ovrValid && (req.refKind == SAG_REF_DATA);
    chosenSeg  = implicitSeg;
    if (ovrApplies) begin
      chosenSeg = req.ovrSeg;
    end
  end

  // Selector and offset registered together as one request
  // Selector is read before any load landing on this same edge
  always_comb begin
    addr_nxt.valid    = req.valid && makesAddr;
    addr_nxt.segSel   = chosenSeg;
    addr_nxt.selector = segFile_r[chosenSeg];
    addr_nxt.offset   = offsetSum;
  end

  // Output register: the single stage between request and answer
  // Reset clears valid so no stale address leaks out
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_r <= '0;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  assign addrOut = addr_r;

endmodule // sag_address_gen

`default_nettype wire

//--- rtl/sag_defines.svh
`ifndef SAG_DEFINES_SVH
`define SAG_DEFINES_SVH

// Word and field widths
`define SAG_WORD_W        16
`define SAG_DISP8_W       8
`define SAG_SEG_CNT       4
// Reset value of every segment register
`define SAG_SEG_RST       16'h0000
// Segment size limit in bytes (one offset wraps at this)
`define SAG_SEG_BYTES     32'h0001_0000
// Pipeline latency from request to address output, cycles
`define SAG_LATENCY       1

`endif

//--- rtl/sag_pkg.sv
package sag_pkg;

  // Segment register choice
  typedef enum logic [1:0] {
    SAG_SEG_CODE  = 2'b00,
    SAG_SEG_STACK = 2'b01,
    SAG_SEG_DATA  = 2'b10,
    SAG_SEG_EXTRA = 2'b11
  } sag_seg_t;

  // Operand addressing modes
  typedef enum logic [2:0] {
    SAG_AM_REG      = 3'b000,
    SAG_AM_IMM      = 3'b001,
    SAG_AM_DIRECT   = 3'b010,
    SAG_AM_INDIRECT = 3'b011,
    SAG_AM_BASED    = 3'b100,
    SAG_AM_INDEXED  = 3'b101,
    SAG_AM_BIX      = 3'b110,
    SAG_AM_BIX_DISP = 3'b111
  } sag_mode_t;

  // Kind of memory reference
  typedef enum logic [1:0] {
    SAG_REF_FETCH = 2'b00,
    SAG_REF_STACK = 2'b01,
    SAG_REF_DATA  = 2'b10,
    SAG_REF_SDST  = 2'b11
  } sag_ref_t;

  // Register choice for offset elements
  typedef enum logic [1:0] {
    SAG_R_SRCIDX = 2'b00,
    SAG_R_DSTIDX = 2'b01,
    SAG_R_GBASE  = 2'b10,
    SAG_R_BPTR   = 2'b11
  } sag_reg_t;

  // Request from the instruction decoder
  typedef struct packed {
    logic        valid;
    sag_ref_t    refKind;
    sag_mode_t   mode;
    logic        baseIsPtr;   // 0 general base, 1 base pointer
    logic        indexIsDst;  // 0 source index, 1 dest index
    sag_reg_t    indirReg;    // register for indirect mode
    logic        disp16;      // 1 for 16-bit displacement
    logic [15:0] disp;
    logic        ovrValid;
    sag_seg_t    ovrSeg;
    logic [15:0] fetchPtr;    // instruction pointer for fetches
  } sag_req_t;

  // Address request toward memory management
  typedef struct packed {
    logic        valid;
    sag_seg_t    segSel;
    logic [15:0] selector;
    logic [15:0] offset;
  } sag_addr_t;

  // Segment register load port
  typedef struct packed {
    logic        we;
    sag_seg_t    seg;
    logic [15:0] value;
  } sag_segwr_t;

endpackage

//--- rtl/sag_offset_adder.sv
`timescale 1ns/1ps
`default_nettype none

// Three-term offset adder, wraps modulo the word width
module sag_offset_adder #(
  parameter int WORD_W = 16
) (
  // Terms
  input  wire logic [WORD_W-1:0] termDisp,
  input  wire logic [WORD_W-1:0] termBase,
  input  wire logic [WORD_W-1:0] termIndex,
  // Result
  output logic      [WORD_W-1:0] sum
);

  // Carry out is dropped by the target width
  always_comb begin
    sum = termDisp + termBase + termIndex;
  end

endmodule // sag_offset_adder

`default_nettype wire

//--- tb/sag_address_gen_checker.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level watch on the generator; answer comes one cycle after the request
module sag_address_gen_checker
  import sag_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // Inputs
  input wire sag_segwr_t  segWr,
  input wire logic [15:0] generalBaseReg,
  input wire logic [15:0] srcIndexReg,
  input wire sag_req_t    req,
  // Outputs
  input wire sag_addr_t   addrOut,
  input wire logic [15:0] codeSegmentReg,
  input wire logic [15:0] stackSegmentReg,
  input wire logic [15:0] dataSegmentReg,
  input wire logic [15:0] extraSegmentReg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Helpers: non-fetch memory modes, short displacement, plain base plus index
  logic        memReq;
  logic [15:0] dispExt;
  logic [15:0] bixSum;
  logic [15:0] selNow;
  assign memReq  = req.valid && req.refKind != SAG_REF_FETCH && (req.mode[2:1] != 2'h0);
  assign dispExt = {{8{req.disp[7]}}, req.disp[7:0]};
  assign bixSum  = generalBaseReg + srcIndexReg;
  assign selNow  = (addrOut.segSel == SAG_SEG_CODE) ? codeSegmentReg :
                   (addrOut.segSel == SAG_SEG_STACK) ? stackSegmentReg :
                   (addrOut.segSel == SAG_SEG_DATA) ? dataSegmentReg : extraSegmentReg;

  AST_FETCH_CODE: assert property (req.valid && req.refKind == SAG_REF_FETCH |=>
    addrOut.valid && addrOut.segSel == SAG_SEG_CODE && addrOut.offset == $past(req.fetchPtr))
    else $error("Fetch not issued on code segment");
  AST_NO_ADDR: assert property (req.valid && req.refKind != SAG_REF_FETCH &&
    req.mode[2:1] == 2'h0 |=> !addrOut.valid) else $error("Address made for register operand");
  AST_STACK_SEG: assert property (memReq && req.refKind == SAG_REF_STACK |=>
    addrOut.valid && addrOut.segSel == SAG_SEG_STACK) else $error("Stack ref off stack segment");
  AST_SDST_SEG: assert property (memReq && req.refKind == SAG_REF_SDST |=>
    addrOut.segSel == SAG_SEG_EXTRA) else $error("String destination off extra segment");
  AST_OVERRIDE: assert property (memReq && req.refKind == SAG_REF_DATA && req.ovrValid |=>
    addrOut.segSel == $past(req.ovrSeg)) else $error("Override segment not used");
  AST_DATA_SEG: assert property (memReq && req.refKind == SAG_REF_DATA && !req.ovrValid &&
    req.mode inside {SAG_AM_DIRECT, SAG_AM_INDEXED} |=> addrOut.segSel == SAG_SEG_DATA)
    else $error("Data ref off data segment");
  AST_DISP8: assert property (memReq && req.mode == SAG_AM_DIRECT && !req.disp16 |=>
    addrOut.offset == $past(dispExt)) else $error("Short displacement not sign extended");
  AST_BIX_SUM: assert property (memReq && req.mode == SAG_AM_BIX && !req.baseIsPtr &&
    !req.indexIsDst |=> addrOut.offset == $past(bixSum)) else $error("Base plus index wrong");
  AST_SEL_PAIR: assert property (addrOut.valid && !$past(segWr.we) |->
    addrOut.selector == selNow) else $error("Selector not paired with segment");
endmodule // sag_address_gen_checker

bind sag_address_gen sag_address_gen_checker u_chk (
  .clk_sys(clk_sys), .rst(rst), .segWr(segWr), .generalBaseReg(generalBaseReg),
  .srcIndexReg(srcIndexReg), .req(req), .addrOut(addrOut),
  .codeSegmentReg(codeSegmentReg), .stackSegmentReg(stackSegmentReg),
  .dataSegmentReg(dataSegmentReg), .extraSegmentReg(extraSegmentReg));

`default_nettype wire

//--- tb/sag_mmu_model.sv
`timescale 1ns/1ps
`default_nettype none

// Memory management side: takes every valid address, never stalls
module sag_mmu_model
  import sag_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Address in
  input wire sag_addr_t  addrIn,
  // Count of taken addresses
  output var logic [7:0] nAddr
);
  // Counting lets the bench spot extra or lost pulses
  always @(posedge clk_sys) begin
    if (rst) begin
      nAddr <= 8'h00;
    end else if (addrIn.valid) begin
      nAddr <= nAddr + 8'h01;
    end
  end
endmodule // sag_mmu_model

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb
  import sag_pkg::*;
;
  // Row: kind, mode, flags {bptr,dst,d16,ovr}, indirect reg, disp, ovr seg, expectations
  typedef struct packed {
    logic [1:0] rk; logic [2:0] md; logic [3:0] flg; logic [1:0] ir;
    logic [15:0] dp; logic [1:0] os; logic ev; logic [1:0] es; logic [15:0] eo;
  } sag_row_t;
  sag_row_t rows [17] = '{
    '{2'h0,3'h0,4'h0,2'h0,16'hbeef,2'h0,1'h1,2'h0,16'hbeef},
    '{2'h2,3'h0,4'h0,2'h0,16'h0000,2'h0,1'h0,2'h0,16'h0000},
    '{2'h2,3'h1,4'h0,2'h0,16'h0000,2'h0,1'h0,2'h0,16'h0000},
    '{2'h2,3'h2,4'h0,2'h0,16'h12ff,2'h0,1'h1,2'h2,16'hffff},
    '{2'h2,3'h2,4'h2,2'h0,16'h1234,2'h0,1'h1,2'h2,16'h1234},
    '{2'h2,3'h3,4'h0,2'h0,16'h0000,2'h0,1'h1,2'h2,16'h0030},
    '{2'h2,3'h3,4'h0,2'h3,16'h0000,2'h0,1'h1,2'h1,16'h2000},
    '{2'h2,3'h4,4'h0,2'h0,16'h0080,2'h0,1'h1,2'h2,16'h0f80},
    '{2'h2,3'h5,4'h6,2'h0,16'h0010,2'h0,1'h1,2'h2,16'h0410},
    '{2'h2,3'h6,4'h8,2'h0,16'hffff,2'h0,1'h1,2'h1,16'h2030},
    '{2'h2,3'h7,4'h6,2'h0,16'hf000,2'h0,1'h1,2'h2,16'h0400},
    '{2'h1,3'h3,4'h1,2'h2,16'h0000,2'h0,1'h1,2'h1,16'h1000},
    '{2'h3,3'h3,4'h1,2'h1,16'h0000,2'h2,1'h1,2'h3,16'h0400},
    '{2'h2,3'h4,4'h9,2'h0,16'h0005,2'h3,1'h1,2'h3,16'h2005},
    '{2'h2,3'h2,4'h3,2'h0,16'h0042,2'h0,1'h1,2'h0,16'h0042},
    '{2'h0,3'h1,4'h1,2'h0,16'h0001,2'h2,1'h1,2'h0,16'h0001},
    '{2'h2,3'h6,4'h0,2'h0,16'h0000,2'h0,1'h1,2'h2,16'h1030}};
  logic [15:0] segv [4] = '{16'h1c5a, 16'h2d6b, 16'h3e7c, 16'h4f8d};

  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  sag_segwr_t  segWr = '0;
  sag_req_t    req = '0;
  sag_addr_t   addrOut;
  logic [15:0] segRd [4];
  logic [7:0]  nAddr;
  int          failures = 0;
  int          nChecks = 0;
  int          cyc = 0;

  always #4 clk_sys = ~clk_sys;

  sag_address_gen DUT (.clk_sys(clk_sys), .rst(rst), .segWr(segWr),
    .generalBaseReg(16'h1000), .basePointerReg(16'h2000), .srcIndexReg(16'h0030),
    .destIndexReg(16'h0400), .req(req), .addrOut(addrOut), .codeSegmentReg(segRd[0]),
    .stackSegmentReg(segRd[1]), .dataSegmentReg(segRd[2]), .extraSegmentReg(segRd[3]));
  sag_mmu_model mmu (.clk_sys(clk_sys), .rst(rst), .addrIn(addrOut), .nAddr(nAddr));

  task automatic print_verdict();
    if (failures == 0 && nChecks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    nChecks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Fetch pointer shares the displacement column
  task automatic drive(input sag_row_t r);
    req <= '{1'b1, sag_ref_t'(r.rk), sag_mode_t'(r.md), r.flg[3], r.flg[2],
             sag_reg_t'(r.ir), r.flg[1], r.dp, r.flg[0], sag_seg_t'(r.os), r.dp};
  endtask

  // Hang guard, far above the roughly 65 cycles used
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      segWr <= '{1'b1, sag_seg_t'(i), segv[i]};
    end
    @(posedge clk_sys);
    segWr.we <= 1'b0;
    #1;
    for (int i = 0; i < 4; i++) chk(segRd[i], segv[i]);
    // Table rows, one request at a time
    for (int i = 0; i < 17; i++) begin
      @(posedge clk_sys);
      drive(rows[i]);
      @(posedge clk_sys);
      req.valid <= 1'b0;
      #1;
      chk({15'h0, addrOut.valid}, {15'h0, rows[i].ev});
      if (rows[i].ev) begin
        chk({14'h0, addrOut.segSel}, {14'h0, rows[i].es});
        chk(addrOut.offset, rows[i].eo);
        chk(addrOut.selector, segv[rows[i].es]);
      end
    end
    // Back to back, with a code load beside the first request
    @(posedge clk_sys);
    segWr <= '{1'b1, SAG_SEG_CODE, 16'h7777};
    drive(rows[0]);
    @(posedge clk_sys);
    segWr.we <= 1'b0;
    drive(rows[15]);
    #1;
    chk(addrOut.selector, segv[0]);
    @(posedge clk_sys);
    req.valid <= 1'b0;
    #1;
    chk(addrOut.selector, 16'h7777);
    chk(addrOut.offset, 16'h0001);
    // Reset in mid-run clears everything; the last address is counted on this edge
    @(posedge clk_sys);
    rst <= 1'b1;
    drive(rows[0]);
    #1;
    chk({8'h00, nAddr}, 16'h0011);
    @(posedge clk_sys);
    rst <= 1'b0;
    drive(rows[5]);
    #1;
    chk(segRd[0], 16'h0000);
    chk({15'h0, addrOut.valid}, 16'h0000);
    // First request right after release sees cleared segments
    @(posedge clk_sys);
    req.valid <= 1'b0;
    #1;
    chk({15'h0, addrOut.valid}, 16'h0001);
    chk(addrOut.selector, 16'h0000);
    chk(addrOut.offset, 16'h0030);
    print_verdict();
  end
endmodule // tb

`default_nettype wire
